// ===== core/lcs_link_regs.sv
// link control and link status configuration registers with power-management gating
//
// Functional notes
// RL1: clock_pm_allow clear holds clock request low
// RL2: clock_pm_allow set lets clock request drive
// RL3: extended_sync lengthens FTS and adds TS2
// RL4: common_clock_config selects reported exit latencies
// RL5: L0s latency 011b shared, 100b asynchronous
// RL6: retrain and disable bits read zero
// RL7: completion boundary stored, own stays 128
// RL8: ASPM field encodes off, L0s, L1, both
// RL9: no ASPM entry unless field enables it
// RL10: control bits 15:9 and 2 read zero
// RL11: status reserved zero, writes ignored
// RL12: slot clock bit reflects common reference
// RL13: training and retrain status read zero
// RL14: lane width reports single lane
// RL15: speed reports 2.5 Gb/s code
`timescale 1ns/1ps
`include "lcs_consts.svh"
module lcs_link_regs
  import lcs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire lcs_cfg_req_t cfg_req_i,
  output logic [15:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic common_reference_clock_input_strap_i,
  input wire logic clock_idle_wish_i,
  input wire lcs_pm_req_t pm_req_i,
  output lcs_pm_grant_t pm_grant_o,
  output logic clock_request_pin_o,
  output logic [2:0] l0s_exit_latency_o,
  output logic rcb_root_128_o,
  output logic [7:0] own_rcb_bytes_o
);
  // the request carrier fixes the address at eight bits
  if (ADDR_W != 8) begin : g_addr_w_check
    $error("lcs_link_regs: ADDR_W must be 8");
  end

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic strap_s;
  lcs_sync2 u_strap_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(common_reference_clock_input_strap_i),
    .q_o(strap_s)
  );

  // ****************************************
  // control register
  // ****************************************
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  wire hit_ctrl = cfg_req_i.addr == `LCS_OFF_LINK_CONTROL;
  wire hit_stat = cfg_req_i.addr == `LCS_OFF_LINK_STATUS;
  // only writable fields are kept; reserved, retrain and disable bits never store
  assign ctrl_d = (cfg_req_i.wr && hit_ctrl) ? (cfg_req_i.wdata & `LCS_CTRL_WMASK) : ctrl_q; // RL6 RL10
  // writes to the status offset fall through with no effect
  always_ff @(posedge clk_i or posedge sys_rst_i) begin // RL11
    if (sys_rst_i) begin
      ctrl_q <= `LCS_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************
  // slot clock capture
  // ****************************************
  logic [1:0] settle_q;
  logic captured_q;
  logic slot_clk_q;
  // strap caught once after reset release, as a slot clock is fixed per board;
  // the synchroniser still shows its reset zero for two edges, so the capture waits for it
  wire strap_ready = settle_q == `LCS_STRAP_SETTLE;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      settle_q <= 2'h0;
      captured_q <= 1'b0;
      slot_clk_q <= 1'b0;
    end else if (!strap_ready) begin
      settle_q <= settle_q + 2'h1;
    end else if (!captured_q) begin
      captured_q <= 1'b1;
      slot_clk_q <= strap_s; // RL12
    end
  end

  wire clock_pm_allow = ctrl_q[`LCS_BIT_CPM];
  wire es_en = ctrl_q[`LCS_BIT_ES];
  wire ccc = ctrl_q[`LCS_BIT_CCC];
  wire [1:0] aspm = ctrl_q[`LCS_ASPM_HI:`LCS_ASPM_LO];

  // ****************************************
  // status word and read path
  // ****************************************
  wire [15:0] stat_w = {`LCS_STAT_RSVD, slot_clk_q, `LCS_STAT_NOFUNC, `LCS_LANE_WIDTH_X1, `LCS_SPEED_2G5}; // RL11 RL12 RL13 RL14 RL15
  // unmapped offsets read as zero rather than holding the last answer
  wire [15:0] rd_mux = hit_ctrl ? ctrl_q : (hit_stat ? stat_w : `LCS_WORD_ZERO);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o <= `LCS_WORD_ZERO;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rdata_o <= cfg_req_i.rd ? rd_mux : cfg_rdata_o;
      cfg_rvalid_o <= cfg_req_i.rd;
    end
  end

  // ****************************************
  // power management outputs
  // ****************************************
  function automatic logic aspm_allows(input logic [1:0] f, input logic want_l1);
    aspm_allows = want_l1 ? f[`LCS_ASPM_HI] : f[`LCS_ASPM_LO]; // RL8
  endfunction

  assign pm_grant_o.l0s_go = pm_req_i.l0s_req && aspm_allows(aspm, 1'b0); // RL9
  assign pm_grant_o.l1_go = pm_req_i.l1_req && aspm_allows(aspm, 1'b1); // RL9
  assign pm_grant_o.ext_sync = pm_req_i.l1_exit && es_en; // RL3
  // low while disabled; when allowed, released high only as the platform may stop the clock
  assign clock_request_pin_o = clock_pm_allow && clock_idle_wish_i; // RL1 RL2
  assign l0s_exit_latency_o = ccc ? `LCS_L0S_LAT_COMMON : `LCS_L0S_LAT_ASYNC; // RL4 RL5
  assign rcb_root_128_o = ctrl_q[`LCS_BIT_RCB]; // RL7
  // the stored root value is only reported; this block's own boundary never moves
  assign own_rcb_bytes_o = `LCS_OWN_RCB_BYTES; // RL7

  // ****************************************
  // checks
  // ****************************************
  // a write into the control word, a read of the status word and its answer
  sequence s_ctrl_wr;
    cfg_req_i.wr && hit_ctrl;
  endsequence

  sequence s_stat_rd;
    cfg_req_i.rd && hit_stat;
  endsequence

  // slot clock bit left out here, as it follows the board strap
  sequence s_stat_answer;
    cfg_rvalid_o && (cfg_rdata_o & ~`LCS_STAT_SCC_MASK) == `LCS_STAT_FIXED;
  endsequence

  // clock request: always low while disabled, and judged again right after each control write
  property p_clock_request_pin_low;
    @(posedge clk_i) disable iff (sys_rst_i) !clock_pm_allow |-> !clock_request_pin_o;
  endproperty
  a_clock_request_pin_low: assert property (p_clock_request_pin_low) else $error("clock request driven while disabled"); // RL1

  property p_cpm_off_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr ##0 !cfg_req_i.wdata[`LCS_BIT_CPM] |=> !clock_request_pin_o;
  endproperty
  a_cpm_off_wr: assert property (p_cpm_off_wr) else $error("clock request after disabling write"); // RL1

  property p_cpm_on_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr ##0 cfg_req_i.wdata[`LCS_BIT_CPM] ##1 clock_idle_wish_i |-> clock_request_pin_o;
  endproperty
  a_cpm_on_wr: assert property (p_cpm_on_wr) else $error("clock request withheld while allowed"); // RL2

  // exit latency follows the common clock bit of the last write
  property p_lat;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr |=> l0s_exit_latency_o ==
        ($past(cfg_req_i.wdata[`LCS_BIT_CCC]) ? `LCS_L0S_LAT_COMMON : `LCS_L0S_LAT_ASYNC);
  endproperty
  a_lat: assert property (p_lat) else $error("l0s latency mismatch"); // RL4

  property p_ctrl_rsvd;
    @(posedge clk_i) disable iff (sys_rst_i) (ctrl_q & ~`LCS_CTRL_WMASK) == `LCS_WORD_ZERO;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("fixed control bit set"); // RL6

  property p_stat_rd;
    @(posedge clk_i) disable iff (sys_rst_i) s_stat_rd |=> s_stat_answer;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read wrong"); // RL14

  property p_stat_wr;
    @(posedge clk_i) disable iff (sys_rst_i) (cfg_req_i.wr && hit_stat) |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write changed state"); // RL11

  // active-state entry: a cleared enable bit blocks the grant from the next cycle on
  property p_l0s;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr ##0 !cfg_req_i.wdata[`LCS_ASPM_LO] |=> !pm_grant_o.l0s_go;
  endproperty
  a_l0s: assert property (p_l0s) else $error("l0s entry not enabled"); // RL9

  property p_l1_off;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr ##0 !cfg_req_i.wdata[`LCS_ASPM_HI] |=> !pm_grant_o.l1_go;
  endproperty
  a_l1_off: assert property (p_l1_off) else $error("l1 entry not enabled"); // RL9

  property p_l1;
    @(posedge clk_i) disable iff (sys_rst_i) (pm_req_i.l1_req && aspm == `LCS_ASPM_BOTH) |-> pm_grant_o.l1_go;
  endproperty
  a_l1: assert property (p_l1) else $error("l1 entry refused"); // RL8

  property p_l0s_on;
    @(posedge clk_i) disable iff (sys_rst_i)
      (pm_req_i.l0s_req && aspm == `LCS_ASPM_L0S) |-> pm_grant_o.l0s_go && !pm_grant_o.l1_go;
  endproperty
  a_l0s_on: assert property (p_l0s_on) else $error("l0s only code decoded wrong"); // RL8

  // extended synchronisation on leaving L1 only while the bit is set
  property p_es;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr ##0 !cfg_req_i.wdata[`LCS_BIT_ES] |=> !pm_grant_o.ext_sync;
  endproperty
  a_es: assert property (p_es) else $error("extended sync unrequested"); // RL3

  property p_es_on;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr ##0 cfg_req_i.wdata[`LCS_BIT_ES] ##1 pm_req_i.l1_exit |-> pm_grant_o.ext_sync;
  endproperty
  a_es_on: assert property (p_es_on) else $error("extended sync missing on l1 exit"); // RL3

  property p_rcb;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ctrl_wr |=> rcb_root_128_o == $past(cfg_req_i.wdata[`LCS_BIT_RCB]) && own_rcb_bytes_o == `LCS_OWN_RCB_BYTES;
  endproperty
  a_rcb: assert property (p_rcb) else $error("completion boundary wrong"); // RL7

  // slot clock bit: taken from the settled strap once, then left alone until the next reset
  property p_slot_capture;
    @(posedge clk_i) disable iff (sys_rst_i)
      (strap_ready && !captured_q) |=> captured_q && slot_clk_q == $past(strap_s);
  endproperty
  a_slot_capture: assert property (p_slot_capture) else $error("slot clock strap not caught"); // RL12

  property p_slot_hold;
    @(posedge clk_i) disable iff (sys_rst_i) captured_q |=> $stable(slot_clk_q);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot clock bit moved"); // RL12
endmodule // lcs_link_regs

// ===== core/lcs_sync2.sv
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module lcs_sync2 (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // lcs_sync2

// ===== inc/lcs_consts.svh
// offsets, field positions and fixed codes of the link control/status register pair
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH
`define LCS_OFF_LINK_CONTROL 8'ha0
`define LCS_OFF_LINK_STATUS 8'ha2
`define LCS_CTRL_RESET 16'h0000
`define LCS_CTRL_WMASK 16'h01cb
`define LCS_BIT_CPM 8
`define LCS_BIT_ES 7
`define LCS_BIT_CCC 6
`define LCS_BIT_RCB 3
`define LCS_ASPM_HI 1
`define LCS_ASPM_LO 0
`define LCS_ASPM_OFF 2'h0
`define LCS_ASPM_L0S 2'h1
`define LCS_ASPM_L1 2'h2
`define LCS_ASPM_BOTH 2'h3
`define LCS_L0S_LAT_COMMON 3'h3
`define LCS_L0S_LAT_ASYNC 3'h4
`define LCS_LANE_WIDTH_X1 6'h01
`define LCS_SPEED_2G5 4'h1
`define LCS_OWN_RCB_BYTES 8'h80
`define LCS_STRAP_SETTLE 2'h2
`define LCS_WORD_ZERO 16'h0000
`define LCS_STAT_RSVD 3'h0
`define LCS_STAT_NOFUNC 2'h0
`define LCS_STAT_FIXED 16'h0011
`define LCS_STAT_SCC_MASK 16'h1000
`endif

// ===== inc/lcs_pkg.sv
// types of the link control/status register block
package lcs_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } lcs_cfg_req_t;
  typedef struct packed {
    logic l0s_req;
    logic l1_req;
    logic l1_exit;
  } lcs_pm_req_t;
  typedef struct packed {
    logic l0s_go;
    logic l1_go;
    logic ext_sync;
  } lcs_pm_grant_t;
endpackage

// ===== tb/lcs_rc_model.sv
// link-layer partner model that raises power-management request levels
`timescale 1ns/1ps
module lcs_rc_model
  import lcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic [2:0] want_i,
  output lcs_pm_req_t pm_req_o
);
  // levels move off the core's sampling edge
  always @(negedge clk_i) pm_req_o <= lcs_pm_req_t'(want_i);
endmodule // lcs_rc_model

// ===== tb/testbench.sv
// self-checking bench for the link control/status registers
`timescale 1ns/1ps
module testbench
  import lcs_pkg::*;
;
  logic clk_i = 0, sys_rst_i = 1, strap = 1, wish = 0, rvalid, crq, read_completion_boundary;
  logic [2:0] want = 0, lat;
  logic [7:0] own;
  logic [15:0] rdata, d;
  lcs_cfg_req_t req = '0;
  lcs_pm_req_t pmr;
  lcs_pm_grant_t gr;
  int err_count = 0, samples_checked = 0;
  lcs_link_regs lcs_link_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_req_i(req),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .common_reference_clock_input_strap_i(strap),
    .clock_idle_wish_i(wish), .pm_req_i(pmr), .pm_grant_o(gr), .clock_request_pin_o(crq),
    .l0s_exit_latency_o(lat), .rcb_root_128_o(read_completion_boundary), .own_rcb_bytes_o(own));
  lcs_rc_model lcs_rc_model_inst (.clk_i(clk_i), .want_i(want), .pm_req_o(pmr));
  initial forever #4 clk_i = ~clk_i;
  // ****************
  // bus tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge clk_i) req = '{1'b1, 1'b0, a, v};
    @(negedge clk_i) req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    bit seen;
    seen = 0;
    @(negedge clk_i) req = '{1'b0, 1'b1, a, 16'h0000};
    // rvalid is a one-cycle pulse, so every edge is looked at
    for (int i = 0; i < 4 && !seen; i++) begin
      @(posedge clk_i) #1;
      if (rvalid === 1'b1) begin
        seen = 1;
        v = rdata;
      end
      if (i == 0) @(negedge clk_i) req = '0;
    end
    if (!seen) begin
      err_count++;
      $display("mismatch at %0t: no read answer", $time);
      final_report();
    end
  endtask
  task automatic final_report();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd(8'ha0, d);
    chk(d, 16'h0000);
    chk(16'(lat), 16'h0004);
    chk(16'(own), 16'h0080);
    $display("reset values done");
  endtask
  task automatic t_mask();
    wr(8'ha0, 16'hffff);
    rd(8'ha0, d);
    chk(d, 16'h01cb);
    chk(16'(lat), 16'h0003);
    chk(16'({read_completion_boundary, own}), 16'h0180);
    $display("write mask done");
  endtask
  task automatic t_clock_request_pin();
    wish = 1;
    wr(8'ha0, 16'h0000);
    chk(16'(crq), 16'h0000);
    wr(8'ha0, 16'h0100);
    chk(16'(crq), 16'h0001);
    wish = 0;
    @(negedge clk_i);
    chk(16'(crq), 16'h0000);
    $display("clock request done");
  endtask
  task automatic t_aspm();
    want = 3'h7;
    // every power-state code, with entry wished for both states
    for (int c = 0; c < 4; c++) begin
      wr(8'ha0, 16'(c));
      chk(16'({gr.l0s_go, gr.l1_go}), 16'({c[0], c[1]}));
    end
    chk(16'(gr.ext_sync), 16'h0000);
    wr(8'ha0, 16'h0083);
    chk(16'(gr.ext_sync), 16'h0001);
    // no request, no grant, even with every entry enabled
    want = 3'h0;
    repeat (2) @(negedge clk_i);
    chk(16'({gr.l0s_go, gr.l1_go, gr.ext_sync}), 16'h0000);
    $display("power states done");
  endtask
  task automatic t_status();
    wr(8'ha2, 16'hffff);
    rd(8'ha2, d);
    chk(d, 16'h1011);
    rd(8'ha0, d);
    chk(d, 16'h0083);
    rd(8'hb0, d);
    chk(d, 16'h0000);
    $display("status done");
  endtask
  task automatic t_strap();
    // second reset with the strap low; it is caught once, so a later change stays unseen
    strap = 0;
    sys_rst_i = 1;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (4) @(negedge clk_i);
    chk(16'(lat), 16'h0004);
    rd(8'ha0, d);
    chk(d, 16'h0000);
    rd(8'ha2, d);
    chk(d, 16'h0011);
    strap = 1;
    repeat (4) @(negedge clk_i);
    rd(8'ha2, d);
    chk(d, 16'h0011);
    $display("second reset done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) sys_rst_i = 0;
    repeat (4) @(negedge clk_i);
    t_reset();
    t_mask();
    t_clock_request_pin();
    t_aspm();
    t_status();
    t_strap();
    final_report();
  end
endmodule // testbench
